// ### dv/carrier_oscillator_phase_regs_asserts.sv
// Concurrent checks on the ports of the oscillator register bank.
// Assumes one clock, clk_sys_i, and the asynchronous active-low reset nrst_i.
`timescale 1ns/1ps
`include "carrier_oscillator_phase_map.vh"
module carrier_oscillator_phase_regs_asserts #(
    parameter TUNING_WIDTH = 48,
    parameter SHIFT_WIDTH = 16,
    parameter SKEW_WIDTH = 13
) (
    // Watched ports
    input wire clk_sys_i,
    input wire nrst_i,
    input wire ce_i,
    input wire [11:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire fine_mod_en_i,
    input wire [TUNING_WIDTH-1:0] active_tuning_word_o,
    input wire [SHIFT_WIDTH-1:0] active_phase_shift_o,
    input wire [SKEW_WIDTH-1:0] quadrature_skew_o,
    input wire tuning_apply_done_o,
    input wire [TUNING_WIDTH-1:0] acc_phase_o,
    input wire [SHIFT_WIDTH-1:0] carrier_phase_o
);
    logic req_reg;
    logic [TUNING_WIDTH-1:0] acc_next;
    logic [SHIFT_WIDTH-1:0] car_next;
    wire wr_ok = ce_i && reg_wr_i;
    wire ctl_wr = wr_ok && reg_addr_i == `ADDR_APPLY_CTRL;
    wire rise = ctl_wr && reg_wdata_i[0] && !req_reg;
    // Mirror of the request bit, so only a real 0-to-1 step counts
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) req_reg <= 1'b0;
        else if (ctl_wr) req_reg <= reg_wdata_i[0];
    end
    always @(posedge clk_sys_i) begin
        acc_next <= ce_i ? acc_phase_o + active_tuning_word_o : acc_phase_o;
        car_next <= ce_i ? acc_phase_o[TUNING_WIDTH-1 -: SHIFT_WIDTH]
            + (fine_mod_en_i ? active_phase_shift_o : '0) : carrier_phase_o;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_skew_lo;
        wr_ok && reg_addr_i == `ADDR_SKEW_LOW
            |=> ##1 quadrature_skew_o[7:0] == $past(reg_wdata_i, 2);
    endproperty
    a_skew_lo: assert property (p_skew_lo)
        else $error("skew low byte not taken");
    property p_skew_hi;
        wr_ok && reg_addr_i == `ADDR_SKEW_HIGH
            |=> ##1 quadrature_skew_o[12:8] == $past(reg_wdata_i[4:0], 2);
    endproperty
    a_skew_hi: assert property (p_skew_hi)
        else $error("skew upper bits not taken");
    property p_skew_rd;
        ce_i && reg_rd_i && reg_addr_i == `ADDR_SKEW_HIGH |=> reg_rdata_o[7:5] == 3'h0;
    endproperty
    a_skew_rd: assert property (p_skew_rd)
        else $error("skew upper spare bits not zero");
    property p_stage;
        !rise |=> $stable(active_tuning_word_o) && $stable(active_phase_shift_o);
    endproperty
    a_stage: assert property (p_stage)
        else $error("active state changed without request edge");
    property p_done;
        rise |=> tuning_apply_done_o;
    endproperty
    a_done: assert property (p_done)
        else $error("done not set after apply");
    property p_clr;
        ctl_wr && !reg_wdata_i[0] |=> !tuning_apply_done_o;
    endproperty
    a_clr: assert property (p_clr)
        else $error("done not cleared");
    property p_acc;
        1'b1 |=> acc_phase_o == acc_next;
    endproperty
    a_acc: assert property (p_acc)
        else $error("accumulator step wrong");
    property p_car;
        1'b1 |=> carrier_phase_o == car_next;
    endproperty
    a_car: assert property (p_car)
        else $error("carrier phase wrong");
endmodule // carrier_oscillator_phase_regs_asserts
bind carrier_oscillator_phase_regs carrier_oscillator_phase_regs_asserts #(
    .TUNING_WIDTH(TUNING_WIDTH), .SHIFT_WIDTH(SHIFT_WIDTH), .SKEW_WIDTH(SKEW_WIDTH)
) u_asserts (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .fine_mod_en_i(fine_mod_en_i),
    .active_tuning_word_o(active_tuning_word_o), .active_phase_shift_o(active_phase_shift_o),
    .quadrature_skew_o(quadrature_skew_o), .tuning_apply_done_o(tuning_apply_done_o),
    .acc_phase_o(acc_phase_o), .carrier_phase_o(carrier_phase_o));

// ### dv/test_carrier_oscillator_phase_regs.sv
// Self-checking bench for the oscillator register bank.
// Assumes the bank, its datapath and the map header are compiled first.
`timescale 1ns/1ps
`include "carrier_oscillator_phase_map.vh"
module test_carrier_oscillator_phase_regs;
    logic clk_sys_i = 0, nrst_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, fine_mod_en_i = 1;
    logic [11:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = '0;
    wire [7:0] reg_rdata_o;
    wire [47:0] active_tuning_word_o, acc_phase_o;
    wire [15:0] active_phase_shift_o, carrier_phase_o;
    wire [12:0] quadrature_skew_o;
    wire tuning_apply_done_o;
    int miscompares = 0, check_count = 0, cycles = 0;
    logic [47:0] acc_hold;
    // Address, write data, read-back, reset value; 0x120 is unmapped
    logic [35:0] rows [0:8] = '{{12'h116, 8'ha1, 8'ha1, 8'h00}, {12'h117, 8'hb2, 8'hb2, 8'h00},
        {12'h118, 8'hc3, 8'hc3, 8'h00}, {12'h119, 8'hd4, 8'hd4, 8'h10},
        {12'h11a, 8'h00, 8'h00, 8'h00}, {12'h11b, 8'h80, 8'h80, 8'h00},
        {12'h11c, 8'h5a, 8'h5a, 8'h00}, {12'h11d, 8'hff, 8'h1f, 8'h00},
        {12'h120, 8'hff, 8'h00, 8'h00}};
    carrier_oscillator_phase_regs u_carrier_oscillator_phase_regs (.clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .fine_mod_en_i(fine_mod_en_i), .active_tuning_word_o(active_tuning_word_o),
        .active_phase_shift_o(active_phase_shift_o), .quadrature_skew_o(quadrature_skew_o),
        .tuning_apply_done_o(tuning_apply_done_o), .acc_phase_o(acc_phase_o),
        .carrier_phase_o(carrier_phase_o));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes drop one edge before the next call raises them again
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // A run needs about 90 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        do_reset();
        for (int i = 0; i < 9; i++) wr(rows[i][35:24], rows[i][23:16]);
        for (int i = 0; i < 9; i++) rd(rows[i][35:24], rows[i][15:8]);
        $display("register read-back done");
        chk(active_tuning_word_o, 48'h0);
        chk(quadrature_skew_o, 13'h1f5a);
        wr(`ADDR_APPLY_CTRL, 8'h01);
        chk(active_tuning_word_o, 48'hd4c3b2a10000);
        chk(active_phase_shift_o, 16'h8000);
        chk(tuning_apply_done_o, 1'b1);
        rd(`ADDR_APPLY_CTRL, 8'h03);
        wr(12'h116, 8'h77);
        wr(`ADDR_APPLY_CTRL, 8'h01);
        chk(active_tuning_word_o, 48'hd4c3b2a10000);
        wr(`ADDR_APPLY_CTRL, 8'h00);
        chk(tuning_apply_done_o, 1'b0);
        wr(`ADDR_APPLY_CTRL, 8'h01);
        chk(active_tuning_word_o, 48'hd4c3b2770000);
        $display("apply sequence done");
        ce_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 acc_hold = acc_phase_o;
        repeat (3) @(posedge clk_sys_i);
        #1 chk(acc_phase_o, acc_hold);
        ce_i <= 1'b1;
        fine_mod_en_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1 acc_hold = acc_phase_o;
        @(posedge clk_sys_i);
        #1 chk(carrier_phase_o, acc_hold[47:32]);
        $display("freeze and gating done");
        do_reset();
        for (int i = 0; i < 9; i++) rd(rows[i][35:24], rows[i][7:0]);
        chk(active_tuning_word_o, 48'h0);
        $display("reset values done");
        print_verdict();
    end
endmodule // test_carrier_oscillator_phase_regs

// ### rtl/carrier_oscillator_phase_map.vh
// Register map, field positions and reset values of the fine-modulation oscillator bank.
// Included by the bank and by the phase datapath; definitions only.
`ifndef CARRIER_OSCILLATOR_PHASE_MAP_VH
`define CARRIER_OSCILLATOR_PHASE_MAP_VH

`define ADDR_APPLY_CTRL 12'h113
`define ADDR_TUNING_BYTE0 12'h114
`define ADDR_TUNING_BYTE1 12'h115
`define ADDR_TUNING_BYTE2 12'h116
`define ADDR_TUNING_BYTE3 12'h117
`define ADDR_TUNING_BYTE4 12'h118
`define ADDR_TUNING_BYTE5 12'h119
`define ADDR_PHASE_SHIFT_LOW 12'h11a
`define ADDR_PHASE_SHIFT_HIGH 12'h11b
`define ADDR_SKEW_LOW 12'h11c
`define ADDR_SKEW_HIGH 12'h11d

`define APPLY_REQ_BIT 0
`define APPLY_DONE_BIT 1
`define SKEW_HIGH_MSB 4

`define RST_TUNING_BYTE 8'h00
`define RST_TUNING_BYTE5 8'h10
`define RST_PHASE_BYTE 8'h00
`define RST_SKEW_BYTE 8'h00
`define RST_APPLY_CTRL 8'h00

`define TUNING_WIDTH 48
`define PHASE_SHIFT_WIDTH 16
`define SKEW_WIDTH 13

`endif

// ### rtl/carrier_oscillator_phase_regs.v
// Register bank of the fine-modulation oscillator: tuning word, carrier phase
// shift and I/Q quadrature skew, with staged update of tuning word and phase shift on request.
// Assumes a byte-wide register port (address, write strobe, read strobe) on clk_sys_i.
`timescale 1ns/1ps
`include "carrier_oscillator_phase_map.vh"

module carrier_oscillator_phase_regs #(
    parameter TUNING_WIDTH = 48,
    parameter SHIFT_WIDTH = 16,
    parameter SKEW_WIDTH = 13
) (
    // Clock, reset, enable
    input wire clk_sys_i,
    input wire nrst_i,
    input wire ce_i,
    // Register port
    input wire [11:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Datapath control
    input wire fine_mod_en_i,
    // Active oscillator state
    output reg [TUNING_WIDTH-1:0] active_tuning_word_o,
    output reg [SHIFT_WIDTH-1:0] active_phase_shift_o,
    output reg [SKEW_WIDTH-1:0] quadrature_skew_o,
    output reg tuning_apply_done_o,
    // Carrier phase
    output wire [TUNING_WIDTH-1:0] acc_phase_o,
    output wire [SHIFT_WIDTH-1:0] carrier_phase_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Staged registers
    reg [7:0] tuning_byte_reg [0:5];
    reg [7:0] phase_low_reg;
    reg [7:0] phase_high_reg;
    reg [7:0] skew_low_reg;
    reg [4:0] skew_high_reg;
    reg apply_req_reg;
    reg apply_done_reg;

    wire wr_en;
    wire req_rise;
    wire [TUNING_WIDTH-1:0] staged_tuning;

    assign wr_en = ce_i & reg_wr_i;
    assign req_rise = wr_en && (reg_addr_i == `ADDR_APPLY_CTRL)
                      && reg_wdata_i[`APPLY_REQ_BIT] && !apply_req_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_tuning
            localparam [11:0] BYTE_ADDR = `ADDR_TUNING_BYTE0 + gi;
            always @(posedge clk_sys_i or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    tuning_byte_reg[gi] <= (gi == 5) ? `RST_TUNING_BYTE5 : `RST_TUNING_BYTE;
                end else if (wr_en && (reg_addr_i == BYTE_ADDR)) begin
                    tuning_byte_reg[gi] <= reg_wdata_i;
                end
            end
            assign staged_tuning[gi*8 +: 8] = tuning_byte_reg[gi];
        end
    endgenerate

    always @(posedge clk_sys_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            phase_low_reg <= `RST_PHASE_BYTE;
            phase_high_reg <= `RST_PHASE_BYTE;
            skew_low_reg <= `RST_SKEW_BYTE;
            skew_high_reg <= 5'h00;
            apply_req_reg <= 1'b0;
        end else if (wr_en) begin
            if (reg_addr_i == `ADDR_PHASE_SHIFT_LOW) begin
                phase_low_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_PHASE_SHIFT_HIGH) begin
                phase_high_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_SKEW_LOW) begin
                skew_low_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_SKEW_HIGH) begin
                skew_high_reg <= reg_wdata_i[`SKEW_HIGH_MSB:0];
            end else if (reg_addr_i == `ADDR_APPLY_CTRL) begin
                apply_req_reg <= reg_wdata_i[`APPLY_REQ_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Apply on rising request; done clears when software drops the request
    always @(posedge clk_sys_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            active_tuning_word_o <= {TUNING_WIDTH{1'b0}};
            active_phase_shift_o <= {SHIFT_WIDTH{1'b0}};
            apply_done_reg <= 1'b0;
            tuning_apply_done_o <= 1'b0;
        end else if (ce_i) begin
            if (req_rise) begin
                active_tuning_word_o <= staged_tuning;
                active_phase_shift_o <= {phase_high_reg, phase_low_reg};
                apply_done_reg <= 1'b1;
            end else if (wr_en && (reg_addr_i == `ADDR_APPLY_CTRL)
                         && !reg_wdata_i[`APPLY_REQ_BIT]) begin
                apply_done_reg <= 1'b0;
            end
            tuning_apply_done_o <= req_rise | (apply_done_reg &
                !(wr_en && (reg_addr_i == `ADDR_APPLY_CTRL) && !reg_wdata_i[`APPLY_REQ_BIT]));
        end
    end

    // Skew is not staged: it drives the I/Q balance one clock after the write reaches the skew registers
    always @(posedge clk_sys_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            quadrature_skew_o <= {SKEW_WIDTH{1'b0}};
        end else if (ce_i) begin
            quadrature_skew_o <= {skew_high_reg, skew_low_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    reg [7:0] rdata_next;

    always @* begin
        rdata_next = 8'h00;
        if (reg_addr_i == `ADDR_APPLY_CTRL) begin
            rdata_next = {6'h00, apply_done_reg, apply_req_reg};
        end else if (reg_addr_i >= `ADDR_TUNING_BYTE0 && reg_addr_i <= `ADDR_TUNING_BYTE5) begin
            rdata_next = tuning_byte_reg[reg_addr_i[2:0] - 3'h4];
        end else if (reg_addr_i == `ADDR_PHASE_SHIFT_LOW) begin
            rdata_next = phase_low_reg;
        end else if (reg_addr_i == `ADDR_PHASE_SHIFT_HIGH) begin
            rdata_next = phase_high_reg;
        end else if (reg_addr_i == `ADDR_SKEW_LOW) begin
            rdata_next = skew_low_reg;
        end else if (reg_addr_i == `ADDR_SKEW_HIGH) begin
            rdata_next = {3'h0, skew_high_reg};
        end
    end

    always @(posedge clk_sys_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    carrier_phase_datapath #(
        .ACC_WIDTH(TUNING_WIDTH),
        .OFFSET_WIDTH(SHIFT_WIDTH)
    ) u_datapath (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_sync_reg),
        .ce_i(ce_i),
        .fine_mod_en_i(fine_mod_en_i),
        .tuning_word_i(active_tuning_word_o),
        .phase_shift_i(active_phase_shift_o),
        .acc_phase_o(acc_phase_o),
        .carrier_phase_o(carrier_phase_o)
    );

endmodule // carrier_oscillator_phase_regs

// ### rtl/carrier_phase_datapath.v
// Phase accumulator and carrier phase generation for the fine-modulation oscillator.
// Assumes active tuning values arrive already applied by the register bank.
`timescale 1ns/1ps
`include "carrier_oscillator_phase_map.vh"

module carrier_phase_datapath #(
    parameter ACC_WIDTH = 48,
    parameter OFFSET_WIDTH = 16
) (
    // Clock, reset and enable
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire ce_i,
    // Controls
    input wire fine_mod_en_i,
    input wire [ACC_WIDTH-1:0] tuning_word_i,
    input wire [OFFSET_WIDTH-1:0] phase_shift_i,
    // Carrier phase
    output reg [ACC_WIDTH-1:0] acc_phase_o,
    output reg [OFFSET_WIDTH-1:0] carrier_phase_o
);

    ////////////////////////////////////////////////////////////////////////////
    wire [OFFSET_WIDTH-1:0] acc_top;
    wire [OFFSET_WIDTH-1:0] offset_used;
    wire [ACC_WIDTH-1:0] acc_next;

    assign acc_next = acc_phase_o + tuning_word_i;
    assign acc_top = acc_phase_o[ACC_WIDTH-1 -: OFFSET_WIDTH];
    // Offset counts only in fine modulation; full scale of 16 bits spans +-180 deg
    assign offset_used = fine_mod_en_i ? phase_shift_i : {OFFSET_WIDTH{1'b0}};

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_phase_o <= {ACC_WIDTH{1'b0}};
            carrier_phase_o <= {OFFSET_WIDTH{1'b0}};
        end else if (ce_i) begin
            acc_phase_o <= acc_next;
            carrier_phase_o <= acc_top + offset_used;
        end
    end

endmodule // carrier_phase_datapath
